// ### common/digit_display_pkg.sv
package digit_display_pkg;

	// ==========================================================
	// geometry
	localparam int DIGIT_COUNT        = 5;
	localparam int STATIC_DIGIT_COUNT = 4;
	localparam int CODE_WIDTH         = 4;
	localparam int SEGMENT_WIDTH      = 7;
	localparam int CODES_WIDTH        = DIGIT_COUNT * CODE_WIDTH;

	// ==========================================================
	// wishbone register map (byte addresses, one word each)
	localparam int WB_ADDR_WIDTH = 8;
	localparam int WB_DATA_WIDTH = 32;
	localparam int WB_SEL_WIDTH  = 4;

	localparam logic [7:0] CONTROL_OFFSET     = 8'h00;
	localparam logic [7:0] CODES_OFFSET       = 8'h04;
	localparam logic [7:0] STATUS_OFFSET      = 8'h08;
	localparam logic [7:0] LATCH_COUNT_OFFSET = 8'h0c;

	// control register fields
	localparam int CONTROL_DYNAMIC_BIT = 0;
	localparam int CONTROL_MINUS_BIT   = 1;
	localparam int CONTROL_POINT_LSB   = 2;
	localparam int CONTROL_WIDTH       = 7;
	localparam logic [6:0] CONTROL_RESET = 7'h00;

	// status register fields
	localparam int STATUS_BLANK_LSB  = 0;
	localparam int STATUS_SELECT_LSB = 5;
	localparam int STATUS_MODE_BIT   = 10;

	localparam int LATCH_COUNT_WIDTH = 16;
	localparam logic [15:0] LATCH_COUNT_ONE = 16'h0001;

	// ==========================================================
	// reset and idle values
	localparam logic [3:0]  CODE_ZERO      = 4'h0;
	localparam logic [19:0] CODES_RESET    = 20'h0_0000;
	localparam logic [4:0]  SELECTS_IDLE   = 5'h1f;
	localparam logic [31:0] WB_DATA_ZERO   = 32'h0000_0000;

	// ==========================================================
	// segment patterns, bit order g f e d c b a
	localparam logic [6:0] SEGMENT_BLANK = 7'h00;
	localparam logic [6:0] SEGMENT_0     = 7'h3f;
	localparam logic [6:0] SEGMENT_1     = 7'h06;
	localparam logic [6:0] SEGMENT_2     = 7'h5b;
	localparam logic [6:0] SEGMENT_3     = 7'h4f;
	localparam logic [6:0] SEGMENT_4     = 7'h66;
	localparam logic [6:0] SEGMENT_5     = 7'h6d;
	localparam logic [6:0] SEGMENT_6     = 7'h7d;
	localparam logic [6:0] SEGMENT_7     = 7'h07;
	localparam logic [6:0] SEGMENT_8     = 7'h7f;
	localparam logic [6:0] SEGMENT_9     = 7'h6f;
	localparam logic [6:0] SEGMENT_A     = 7'h77;
	localparam logic [6:0] SEGMENT_B     = 7'h7c;
	localparam logic [6:0] SEGMENT_C     = 7'h39;
	localparam logic [6:0] SEGMENT_D     = 7'h5e;
	localparam logic [6:0] SEGMENT_E     = 7'h79;
	localparam logic [6:0] SEGMENT_F     = 7'h71;

	typedef enum logic [1:0] {
		MODE_STATIC  = 2'b01,
		MODE_DYNAMIC = 2'b10
	} input_mode_type;

endpackage

// ### rtl/digit_display_input_latch.sv
// Local design decisions: register access over Wishbone and the placing of the registers.
module digit_display_input_latch (
	input  wire logic                                        i_clock,
	input  wire logic                                        i_reset,
	input  wire logic                                        i_wb_cyc,
	input  wire logic                                        i_wb_stb,
	input  wire logic                                        i_wb_we,
	input  wire logic [digit_display_pkg::WB_ADDR_WIDTH-1:0] i_wb_adr,
	input  wire logic [digit_display_pkg::WB_DATA_WIDTH-1:0] i_wb_dat,
	input  wire logic [digit_display_pkg::WB_SEL_WIDTH-1:0]  i_wb_sel,
	output logic                                             o_wb_ack,
	output logic      [digit_display_pkg::WB_DATA_WIDTH-1:0] o_wb_dat,
	input  wire logic [digit_display_pkg::CODE_WIDTH-1:0]    i_first_digit_code,
	input  wire logic [digit_display_pkg::CODE_WIDTH-1:0]    i_second_digit_code,
	input  wire logic [digit_display_pkg::CODE_WIDTH-1:0]    i_third_digit_code,
	input  wire logic [digit_display_pkg::CODE_WIDTH-1:0]    i_fourth_digit_code,
	input  wire logic [digit_display_pkg::CODE_WIDTH-1:0]    i_shared_digit_code,
	input  wire logic                                        i_units_digit_select_n,
	input  wire logic                                        i_tens_digit_select_n,
	input  wire logic                                        i_hundreds_digit_select_n,
	input  wire logic                                        i_thousands_digit_select_n,
	input  wire logic                                        i_ten_thousands_digit_select_n,
	output logic      [digit_display_pkg::SEGMENT_WIDTH-1:0] o_units_segments,
	output logic      [digit_display_pkg::SEGMENT_WIDTH-1:0] o_tens_segments,
	output logic      [digit_display_pkg::SEGMENT_WIDTH-1:0] o_hundreds_segments,
	output logic      [digit_display_pkg::SEGMENT_WIDTH-1:0] o_thousands_segments,
	output logic      [digit_display_pkg::SEGMENT_WIDTH-1:0] o_ten_thousands_segments,
	output logic                                             o_minus_symbol,
	output logic      [digit_display_pkg::DIGIT_COUNT-1:0]   o_decimal_points
);

	import digit_display_pkg::*;

	// ==========================================================
	// synchronised pins
	logic [CODE_WIDTH*STATIC_DIGIT_COUNT-1:0] static_codes_async;
	logic [CODE_WIDTH*STATIC_DIGIT_COUNT-1:0] static_codes_sync;
	logic [CODE_WIDTH-1:0]                    shared_code_sync;
	logic [DIGIT_COUNT-1:0]                   selects_async_n;
	logic [DIGIT_COUNT-1:0]                   selects_sync_n;
	logic [DIGIT_COUNT-1:0]                   selects_prev_n_reg;

	assign static_codes_async = {
		i_fourth_digit_code,
		i_third_digit_code,
		i_second_digit_code,
		i_first_digit_code
	};
	assign selects_async_n = {
		i_ten_thousands_digit_select_n,
		i_thousands_digit_select_n,
		i_hundreds_digit_select_n,
		i_tens_digit_select_n,
		i_units_digit_select_n
	};

	// data and strobes share one latency so a latched code never mixes old and new bits
	input_synchroniser #(
		.WIDTH      (CODE_WIDTH * STATIC_DIGIT_COUNT),
		.IDLE_VALUE (WB_DATA_ZERO)
	) static_sync (
		.i_clock (i_clock),
		.i_reset (i_reset),
		.i_async (static_codes_async),
		.o_sync  (static_codes_sync)
	);

	input_synchroniser #(
		.WIDTH      (CODE_WIDTH),
		.IDLE_VALUE (WB_DATA_ZERO)
	) shared_sync (
		.i_clock (i_clock),
		.i_reset (i_reset),
		.i_async (i_shared_digit_code),
		.o_sync  (shared_code_sync)
	);

	input_synchroniser #(
		.WIDTH      (DIGIT_COUNT),
		.IDLE_VALUE ({27'h000_0000, SELECTS_IDLE})
	) select_sync (
		.i_clock (i_clock),
		.i_reset (i_reset),
		.i_async (selects_async_n),
		.o_sync  (selects_sync_n)
	);

	// ==========================================================
	// control state
	logic [CONTROL_WIDTH-1:0]     control_reg;
	input_mode_type               mode;
	logic [LATCH_COUNT_WIDTH-1:0] latch_count_reg;

	// a mode change keeps every latch, so dynamic digits come back unchanged
	assign mode = control_reg[CONTROL_DYNAMIC_BIT] ? MODE_DYNAMIC : MODE_STATIC;

	// ==========================================================
	// dynamic latches, one per digit
	logic [CODE_WIDTH-1:0] latched_code_reg [DIGIT_COUNT];
	logic [CODE_WIDTH-1:0] shown_code       [DIGIT_COUNT];
	logic [DIGIT_COUNT-1:0] code_is_zero;
	logic [DIGIT_COUNT-1:0] blank;
	logic [SEGMENT_WIDTH-1:0] segments_next [DIGIT_COUNT];
	logic [SEGMENT_WIDTH-1:0] segments_reg  [DIGIT_COUNT];
	logic [CODES_WIDTH-1:0]   shown_codes_flat;

	genvar digit;
	generate
		for (digit = 0; digit < DIGIT_COUNT; digit++) begin : gen_digit
			// follows the bus while its strobe is low; a strobe that stays high holds
			always_ff @(posedge i_clock) begin
				if (i_reset) begin
					latched_code_reg[digit] <= CODE_ZERO;
				end else if (mode == MODE_DYNAMIC && !selects_sync_n[digit]) begin
					latched_code_reg[digit] <= shared_code_sync;
				end
			end

			// the fifth position has no static lines, so it reads as zero and blanks
			if (digit < STATIC_DIGIT_COUNT) begin : gen_static
				always_comb begin
					if (mode == MODE_STATIC) begin
						shown_code[digit] = static_codes_sync[digit*CODE_WIDTH +: CODE_WIDTH];
					end else begin
						shown_code[digit] = latched_code_reg[digit];
					end
				end
			end else begin : gen_dynamic_only
				always_comb begin
					if (mode == MODE_STATIC) begin
						shown_code[digit] = CODE_ZERO;
					end else begin
						shown_code[digit] = latched_code_reg[digit];
					end
				end
			end

			assign code_is_zero[digit] = (shown_code[digit] == CODE_ZERO);
			assign shown_codes_flat[digit*CODE_WIDTH +: CODE_WIDTH] = shown_code[digit];

			// a zero blanks only when every digit above it is blank; units always show
			if (digit == 0) begin : gen_units
				assign blank[digit] = 1'b0;
			end else if (digit == DIGIT_COUNT - 1) begin : gen_top
				assign blank[digit] = code_is_zero[digit];
			end else begin : gen_middle
				assign blank[digit] = code_is_zero[digit] & blank[digit+1];
			end

			digit_segment_decoder decoder (
				.i_code     (shown_code[digit]),
				.i_blank    (blank[digit]),
				.o_segments (segments_next[digit])
			);

			always_ff @(posedge i_clock) begin
				if (i_reset) begin
					segments_reg[digit] <= SEGMENT_BLANK;
				end else begin
					segments_reg[digit] <= segments_next[digit];
				end
			end
		end
	endgenerate

	assign o_units_segments         = segments_reg[0];
	assign o_tens_segments          = segments_reg[1];
	assign o_hundreds_segments      = segments_reg[2];
	assign o_thousands_segments     = segments_reg[3];
	assign o_ten_thousands_segments = segments_reg[4];

	// ==========================================================
	// fixed symbols, independent of any data line
	logic                   minus_reg;
	logic [DIGIT_COUNT-1:0] points_reg;

	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			minus_reg <= 1'b0;
		end else begin
			minus_reg <= control_reg[CONTROL_MINUS_BIT];
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			points_reg <= '0;
		end else begin
			points_reg <= control_reg[CONTROL_POINT_LSB +: DIGIT_COUNT];
		end
	end

	assign o_minus_symbol   = minus_reg;
	assign o_decimal_points = points_reg;

	// ==========================================================
	// completed strobes, counted on the rising edge of a select
	logic [DIGIT_COUNT-1:0] strobe_done;
	logic                   any_strobe_done;

	assign strobe_done     = selects_sync_n & ~selects_prev_n_reg;
	assign any_strobe_done = |strobe_done;

	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			selects_prev_n_reg <= SELECTS_IDLE;
		end else begin
			selects_prev_n_reg <= selects_sync_n;
		end
	end

	// counts at most one per cycle; simultaneous strobes are a controller fault anyway
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			latch_count_reg <= '0;
		end else if (mode == MODE_DYNAMIC && any_strobe_done) begin
			latch_count_reg <= latch_count_reg + LATCH_COUNT_ONE;
		end
	end

	// ==========================================================
	// wishbone classic slave, one wait state
	// ack is registered, so a write lands on the taking edge, the same edge that raises ack
	logic                     request;
	logic                     ack_reg;
	logic [WB_DATA_WIDTH-1:0] read_data_reg;
	logic [WB_DATA_WIDTH-1:0] read_data_next;
	logic [WB_DATA_WIDTH-1:0] status_word;
	logic                     hit_control;
	logic                     hit_codes;
	logic                     hit_status;
	logic                     hit_count;
	logic                     control_write;
	logic                     read_take;

	assign request       = i_wb_cyc & i_wb_stb & ~ack_reg;
	assign hit_control   = (i_wb_adr == CONTROL_OFFSET);
	assign hit_codes     = (i_wb_adr == CODES_OFFSET);
	assign hit_status    = (i_wb_adr == STATUS_OFFSET);
	assign hit_count     = (i_wb_adr == LATCH_COUNT_OFFSET);
	assign control_write = request & i_wb_we & hit_control & i_wb_sel[0];
	assign read_take     = request & ~i_wb_we;

	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= request;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			control_reg <= CONTROL_RESET;
		end else if (control_write) begin
			control_reg <= i_wb_dat[CONTROL_WIDTH-1:0];
		end
	end

	// select levels are shown after the synchroniser, as the latches see them
	always_comb begin
		status_word = WB_DATA_ZERO;
		status_word[STATUS_BLANK_LSB +: DIGIT_COUNT]  = blank;
		status_word[STATUS_SELECT_LSB +: DIGIT_COUNT] = selects_sync_n;
		status_word[STATUS_MODE_BIT]                  = (mode == MODE_DYNAMIC);
	end

	// unmapped addresses still answer, reading zero and ignoring writes
	always_comb begin
		read_data_next = WB_DATA_ZERO;
		if (hit_control) begin
			read_data_next[CONTROL_WIDTH-1:0] = control_reg;
		end else if (hit_codes) begin
			read_data_next[CODES_WIDTH-1:0] = shown_codes_flat;
		end else if (hit_status) begin
			read_data_next = status_word;
		end else if (hit_count) begin
			read_data_next[LATCH_COUNT_WIDTH-1:0] = latch_count_reg;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			read_data_reg <= WB_DATA_ZERO;
		end else if (read_take) begin
			read_data_reg <= read_data_next;
		end
	end

	assign o_wb_ack = ack_reg;
	assign o_wb_dat = read_data_reg;

endmodule

// ### rtl/digit_segment_decoder.sv
module digit_segment_decoder (
	input  wire logic [digit_display_pkg::CODE_WIDTH-1:0]    i_code,
	input  wire logic                                        i_blank,
	output logic      [digit_display_pkg::SEGMENT_WIDTH-1:0] o_segments
);

	import digit_display_pkg::*;

	// ==========================================================
	// numerals then hexadecimal letters
	always_comb begin
		o_segments = SEGMENT_BLANK;
		if (!i_blank) begin
			case (i_code)
				4'h0: o_segments = SEGMENT_0;
				4'h1: o_segments = SEGMENT_1;
				4'h2: o_segments = SEGMENT_2;
				4'h3: o_segments = SEGMENT_3;
				4'h4: o_segments = SEGMENT_4;
				4'h5: o_segments = SEGMENT_5;
				4'h6: o_segments = SEGMENT_6;
				4'h7: o_segments = SEGMENT_7;
				4'h8: o_segments = SEGMENT_8;
				4'h9: o_segments = SEGMENT_9;
				4'ha: o_segments = SEGMENT_A;
				4'hb: o_segments = SEGMENT_B;
				4'hc: o_segments = SEGMENT_C;
				4'hd: o_segments = SEGMENT_D;
				4'he: o_segments = SEGMENT_E;
				default: o_segments = SEGMENT_F;
			endcase
		end
	end

endmodule

// ### rtl/input_synchroniser.sv
module input_synchroniser #(
	parameter int          WIDTH      = 1,
	parameter logic [31:0] IDLE_VALUE = 32'h0000_0000
) (
	input  wire logic             i_clock,
	input  wire logic             i_reset,
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);

	logic [WIDTH-1:0] first_reg;
	logic [WIDTH-1:0] second_reg;

	// ==========================================================
	// two stages; only the second stage is seen outside
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			first_reg  <= IDLE_VALUE[WIDTH-1:0];
			second_reg <= IDLE_VALUE[WIDTH-1:0];
		end else begin
			first_reg  <= i_async;
			second_reg <= first_reg;
		end
	end

	assign o_sync = second_reg;

endmodule

// ### sim/controller_output_model.sv
// ==========================================
// controller output unit, static or strobed
module controller_output_model (
	input  wire logic        i_clock,
	output logic      [15:0] o_static_codes,
	output logic      [3:0]  o_shared_code,
	output logic      [4:0]  o_selects_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic controller_output_mode_switch = 1'b0;
	logic controller_polarity_switch = 1'b1;
	initial begin
		o_static_codes = 16'h0000;
		o_shared_code = 4'h0;
		o_selects_n = 5'h1f;
	end
	task automatic set_mode(input logic dynamic);
		@(posedge i_clock);
		controller_output_mode_switch <= dynamic;
		controller_polarity_switch <= 1'b1;
		// unused static lines float: show the inverse, not the old value
		if (dynamic)
			o_static_codes <= ~o_static_codes;
	endtask
	task automatic set_static(input logic [15:0] c);
		@(posedge i_clock);
		if (!controller_output_mode_switch)
			o_static_codes <= controller_polarity_switch ? c : ~c;
	endtask
	task automatic strobe(input int digit, input logic [7:0] data);
		if (controller_output_mode_switch) begin
			@(posedge i_clock);
			o_shared_code <= data[3:0];
			@(posedge i_clock);
			o_selects_n[digit] <= 1'b0;
			repeat (3) @(posedge i_clock);
			o_selects_n[digit] <= 1'b1;
			repeat (3) @(posedge i_clock);
			o_shared_code <= ~data[3:0];
		end
	endtask
endmodule

// ### sim/digit_display_asserts.sv
// ==========================================
// bus handshake and display checks
module digit_display_asserts (
	input wire logic        i_clock,
	input wire logic        i_reset,
	input wire logic        i_wb_cyc,
	input wire logic        i_wb_stb,
	input wire logic        i_wb_we,
	input wire logic [7:0]  i_wb_adr,
	input wire logic [31:0] i_wb_dat,
	input wire logic [3:0]  i_wb_sel,
	input wire logic        o_wb_ack,
	input wire logic [31:0] o_wb_dat,
	input wire logic        i_units_digit_select_n,
	input wire logic [6:0]  o_units_segments,
	input wire logic        o_minus_symbol,
	input wire logic [4:0]  o_decimal_points
);
	timeunit 1ns;
	timeprecision 1ps;
	import digit_display_pkg::*;
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_reset);
	logic taken;
	logic ctrl_write;
	logic dyn_mode_reg;
	assign taken = i_wb_cyc && i_wb_stb && !o_wb_ack;
	assign ctrl_write = taken && i_wb_we && i_wb_adr == CONTROL_OFFSET && i_wb_sel[0];
	// mode mirror, so the hold check only runs while strobes are honoured
	always_ff @(posedge i_clock) begin
		if (i_reset)
			dyn_mode_reg <= 1'b0;
		else if (ctrl_write)
			dyn_mode_reg <= i_wb_dat[CONTROL_DYNAMIC_BIT];
	end
	sequence s_control_write;
		ctrl_write ##1 1'b1;
	endsequence
	sequence s_units_idle;
		(dyn_mode_reg && i_units_digit_select_n) [*7];
	endsequence
	a_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
		else $error("ack held longer than one cycle");
	a_ack_latency: assert property (taken |=> o_wb_ack)
		else $error("ack missing one cycle after request");
	a_ack_cause: assert property ($rose(o_wb_ack) |-> $past(taken))
		else $error("ack without request");
	a_unmapped_zero: assert property (taken && !i_wb_we && i_wb_adr > LATCH_COUNT_OFFSET
		|=> o_wb_dat == WB_DATA_ZERO)
		else $error("unmapped read returned data");
	a_units_shown: assert property (!$past(i_reset) |-> o_units_segments != SEGMENT_BLANK)
		else $error("units digit blanked");
	a_minus_follows: assert property (s_control_write
		|=> o_minus_symbol == $past(i_wb_dat[CONTROL_MINUS_BIT], 2))
		else $error("minus output does not follow control write");
	a_points_follow: assert property (s_control_write
		|=> o_decimal_points == $past(i_wb_dat[6:2], 2))
		else $error("points output does not follow control write");
	a_marks_steady: assert property (($changed(o_minus_symbol) || $changed(o_decimal_points))
		&& !$past(i_reset) |-> $past(ctrl_write, 2))
		else $error("marks changed without control write");
	a_units_hold: assert property (s_units_idle |-> $stable(o_units_segments))
		else $error("units digit changed without strobe");
endmodule

bind digit_display_input_latch digit_display_asserts u_asserts (.i_clock, .i_reset, .i_wb_cyc,
	.i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_dat, .i_wb_sel, .o_wb_ack, .o_wb_dat,
	.i_units_digit_select_n, .o_units_segments, .o_minus_symbol, .o_decimal_points);

// ### sim/tb_digit_display_input_latch.sv
// ==========================================
// display latch bench
module tb_digit_display_input_latch;
	timeunit 1ns;
	timeprecision 1ps;
	import digit_display_pkg::*;
	logic        i_clock = 1'b0;
	logic        i_reset = 1'b1;
	logic        i_wb_cyc = 1'b0;
	logic        i_wb_stb = 1'b0;
	logic        i_wb_we = 1'b0;
	logic [7:0]  i_wb_adr = 8'h00;
	logic [31:0] i_wb_dat = 32'h0000_0000;
	logic [3:0]  i_wb_sel = 4'h0;
	logic        o_wb_ack;
	logic [31:0] o_wb_dat;
	logic [15:0] static_codes;
	logic [3:0]  shared_code;
	logic [4:0]  selects_n;
	logic [6:0]  o_units_segments, o_tens_segments, o_hundreds_segments;
	logic [6:0]  o_thousands_segments, o_ten_thousands_segments;
	logic        o_minus_symbol;
	logic [4:0]  o_decimal_points;
	int          fail_count = 0;
	int          comparisons = 0;
	int          cycles = 0;
	logic [19:0] codes;
	logic [31:0] rd;
	logic [31:0] base;
	localparam logic [6:0] SEG_TABLE [16] = '{SEGMENT_0, SEGMENT_1, SEGMENT_2, SEGMENT_3,
		SEGMENT_4, SEGMENT_5, SEGMENT_6, SEGMENT_7, SEGMENT_8, SEGMENT_9, SEGMENT_A,
		SEGMENT_B, SEGMENT_C, SEGMENT_D, SEGMENT_E, SEGMENT_F};

	controller_output_model partner (.i_clock, .o_static_codes(static_codes),
		.o_shared_code(shared_code), .o_selects_n(selects_n));
	digit_display_input_latch dut (.i_clock, .i_reset, .i_wb_cyc, .i_wb_stb, .i_wb_we,
		.i_wb_adr, .i_wb_dat, .i_wb_sel, .o_wb_ack, .o_wb_dat,
		.i_first_digit_code(static_codes[3:0]), .i_second_digit_code(static_codes[7:4]),
		.i_third_digit_code(static_codes[11:8]), .i_fourth_digit_code(static_codes[15:12]),
		.i_shared_digit_code(shared_code), .i_units_digit_select_n(selects_n[0]),
		.i_tens_digit_select_n(selects_n[1]), .i_hundreds_digit_select_n(selects_n[2]),
		.i_thousands_digit_select_n(selects_n[3]),
		.i_ten_thousands_digit_select_n(selects_n[4]), .o_units_segments,
		.o_tens_segments, .o_hundreds_segments, .o_thousands_segments,
		.o_ten_thousands_segments, .o_minus_symbol, .o_decimal_points);

	initial begin
		forever #20 i_clock = ~i_clock;
	end
	// whole run needs a few hundred cycles
	always @(posedge i_clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fail_count++;
			print_verdict();
		end
	end

	task automatic print_verdict();
		if (fail_count == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic check_word(input logic [31:0] act, input logic [31:0] exp);
		comparisons++;
		if (act !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: word %h expected %h", $time, act, exp);
		end
	endtask
	task automatic check_display(input logic [19:0] c);
		logic [34:0] exp;
		logic        blank;
		blank = 1'b1;
		for (int i = 4; i >= 0; i--) begin
			blank = blank && c[i*4+:4] == CODE_ZERO && i > 0;
			exp[i*7+:7] = blank ? SEGMENT_BLANK : SEG_TABLE[c[i*4+:4]];
		end
		comparisons++;
		if ({o_ten_thousands_segments, o_thousands_segments, o_hundreds_segments,
			o_tens_segments, o_units_segments} !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: display wrong for codes %h", $time, c);
		end
	endtask
	task automatic wb_cycle(input logic [7:0] adr, input logic we, input logic [31:0] dat,
		input logic [3:0] sel);
		@(posedge i_clock);
		i_wb_cyc <= 1'b1;
		i_wb_stb <= 1'b1;
		i_wb_we <= we;
		i_wb_adr <= adr;
		i_wb_dat <= dat;
		i_wb_sel <= sel;
		// the slave sets the latency; a hang is ended by the bench timeout
		do begin
			@(posedge i_clock);
		end while (o_wb_ack !== 1'b1);
		rd = o_wb_dat;
		i_wb_cyc <= 1'b0;
		i_wb_stb <= 1'b0;
	endtask

	task automatic test_reset();
		wb_cycle(CONTROL_OFFSET, 1'b0, WB_DATA_ZERO, 4'hf);
		check_word(rd, WB_DATA_ZERO);
		check_word(32'({o_minus_symbol, o_decimal_points}), WB_DATA_ZERO);
		check_display(CODES_RESET);
	endtask
	task automatic test_static();
		logic [15:0] pats [2];
		pats = '{16'h0700, 16'hc0a0};
		for (int c = 0; c < 16; c++) begin
			partner.set_static({12'h000, 4'(c)});
			repeat (6) @(posedge i_clock);
			check_display({16'h0000, 4'(c)});
		end
		foreach (pats[k]) begin
			partner.set_static(pats[k]);
			repeat (6) @(posedge i_clock);
			check_display({4'h0, pats[k]});
		end
		wb_cycle(CODES_OFFSET, 1'b0, WB_DATA_ZERO, 4'hf);
		check_word(rd, 32'h0000_c0a0);
	endtask
	task automatic test_dynamic();
		wb_cycle(CONTROL_OFFSET, 1'b1, 32'h0000_0001, 4'h1);
		partner.set_mode(1'b1);
		wb_cycle(LATCH_COUNT_OFFSET, 1'b0, WB_DATA_ZERO, 4'hf);
		base = rd;
		codes = CODES_RESET;
		for (int d = 0; d < 5; d++) begin
			partner.strobe(d, {4'ha, 4'(d + 1)});
			codes[d*4+:4] = 4'(d + 1);
		end
		check_display(codes);
		partner.strobe(1, 8'h59);
		codes[7:4] = 4'h9;
		check_display(codes);
		partner.strobe(4, 8'hf0);
		partner.strobe(3, 8'h00);
		codes[19:12] = 8'h00;
		check_display(codes);
		wb_cycle(CODES_OFFSET, 1'b0, WB_DATA_ZERO, 4'hf);
		check_word(rd, 32'(codes));
		wb_cycle(LATCH_COUNT_OFFSET, 1'b0, WB_DATA_ZERO, 4'hf);
		check_word(32'(16'(rd - base)), 32'h0000_0008);
		wb_cycle(STATUS_OFFSET, 1'b0, WB_DATA_ZERO, 4'hf);
		// mode on, selects idle, digits four and three suppressed
		check_word(32'(rd[10:0]), 32'h0000_07f8);
	endtask
	task automatic test_marks();
		wb_cycle(CONTROL_OFFSET, 1'b1, 32'h0000_007f, 4'h1);
		wb_cycle(CONTROL_OFFSET, 1'b1, 32'h0000_0001, 4'he);
		wb_cycle(CONTROL_OFFSET, 1'b0, WB_DATA_ZERO, 4'hf);
		check_word(rd, 32'h0000_007f);
		check_word(32'({o_minus_symbol, o_decimal_points}), 32'h0000_003f);
		wb_cycle(CONTROL_OFFSET, 1'b1, 32'h0000_0055, 4'h1);
		repeat (2) @(posedge i_clock);
		check_word(32'({o_minus_symbol, o_decimal_points}), 32'h0000_0015);
		check_display(codes);
		wb_cycle(8'h10, 1'b0, WB_DATA_ZERO, 4'hf);
		check_word(rd, WB_DATA_ZERO);
		wb_cycle(CODES_OFFSET, 1'b1, 32'h000f_ffff, 4'hf);
		wb_cycle(CODES_OFFSET, 1'b0, WB_DATA_ZERO, 4'hf);
		check_word(rd, 32'(codes));
	endtask

	initial begin
		repeat (8) @(posedge i_clock);
		i_reset <= 1'b0;
		test_reset();
		test_static();
		test_dynamic();
		test_marks();
		print_verdict();
	end
endmodule
